// ### logic/mtc_pkg.sv
// Shared constants, register map and mode decoding for the timer channel configuration block
package mtc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_BASE = 8'h00;
    localparam logic [7:0] IO_BASE = 8'h20;
    localparam logic [7:0] START_OFS = 8'h40;
    localparam logic [7:0] PSC_OFS = 8'h44;
    localparam logic [7:0] EFF_OFS = 8'h48;
    localparam int unsigned NUM_CH = 5;
    localparam int unsigned NUM_IO = 8;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_RSVD_VAL = 2'h3;
    localparam logic [5:0] MODE_RST = 6'h00;
    localparam logic [7:0] IO_RST = 8'h00;
    localparam int unsigned MODE_BFB_BIT = 5;
    localparam int unsigned MODE_BFA_BIT = 4;
    localparam int unsigned IO_B_LSB = 4;
    localparam int unsigned PSC4_LSB = 3;
    localparam logic [2:0] PSC_RST = 3'h0;

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    localparam int unsigned DIV_CNT_W = 10;
    localparam int unsigned NUM_DIV = 6;
    localparam logic [2:0] PSC_EXT_A = 3'h6;
    localparam logic [2:0] PSC_EXT_B = 3'h7;

    // ------------------------------------------------------------
    // Operating mode codes
    // ------------------------------------------------------------
    localparam logic [3:0] MD_NORMAL = 4'h0;
    localparam logic [3:0] MD_PWM1 = 4'h2;
    localparam logic [3:0] MD_PWM2 = 4'h3;
    localparam logic [3:0] MD_PHASE1 = 4'h4;
    localparam logic [3:0] MD_PHASE4 = 4'h7;
    localparam logic [3:0] MD_RSPWM = 4'h8;
    localparam logic [3:0] MD_CPWM_PEAK = 4'hd;
    localparam logic [3:0] MD_CPWM_VALLEY = 4'he;
    localparam logic [3:0] MD_CPWM_BOTH = 4'hf;

    typedef enum logic [2:0] {
        MODE_NORMAL, MODE_PWM1, MODE_PWM2, MODE_PHASE, MODE_RSPWM, MODE_CPWM, MODE_RESERVED
    } mtc_mode_e;

    function automatic mtc_mode_e decode_mode(input logic [3:0] md);
        mtc_mode_e m;
        m = MODE_RESERVED;
        if (md == MD_NORMAL) m = MODE_NORMAL;
        else if (md == MD_PWM1) m = MODE_PWM1;
        else if (md == MD_PWM2) m = MODE_PWM2;
        else if (md >= MD_PHASE1 && md <= MD_PHASE4) m = MODE_PHASE;
        else if (md == MD_RSPWM) m = MODE_RSPWM;
        else if (md >= MD_CPWM_PEAK) m = MODE_CPWM;
        return m;
    endfunction

endpackage

// ### logic/mtc_tick_if.sv
// Divided peripheral clock ticks passed from the prescaler to the tick selectors
`timescale 1ns/10ps
interface mtc_tick_if;
    logic [5:0] div_tick;
    modport src (output div_tick);
    modport dst (input div_tick);
endinterface

// ### logic/mtc_prescaler.sv
// Free-running divider making one-cycle enables at clk/1, /4, /16, /64, /256 and /1024
`timescale 1ns/10ps
module mtc_prescaler
    import mtc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Tick output
    mtc_tick_if.src tk
);
    logic [DIV_CNT_W-1:0] cnt_q;
    logic [NUM_DIV-1:0] tick_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Tick k fires when the low 2k counter bits are all ones
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_q <= '0;
        end else begin
            tick_q[0] <= 1'b1;
            for (int k = 1; k < NUM_DIV; k++) begin
                tick_q[k] <= &(cnt_q | ~DIV_CNT_W'((1 << (2 * k)) - 1));
            end
        end
    end

    assign tk.div_tick = tick_q;

    chk_div4_period: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_q[1] |=> !tick_q[1] [*3] ##1 tick_q[1])
        else $error("divide-by-4 tick period wrong");

endmodule

// ### logic/mtc_tick_sel.sv
// Count-clock source selection for one channel: internal divided tick or external input edge
`timescale 1ns/10ps
module mtc_tick_sel
    import mtc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Selection and sources
    input wire logic [2:0] psc_i,
    input wire logic ext_a_i,
    input wire logic ext_b_i,
    mtc_tick_if.dst tk,
    // Count enable
    output logic tick_o
);
    logic ext_a_q;
    logic ext_b_q;
    logic tick_d;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_a_q <= 1'b0;
            ext_b_q <= 1'b0;
        end else begin
            ext_a_q <= ext_a_i;
            ext_b_q <= ext_b_i;
        end
    end

    always_comb begin
        if (psc_i == PSC_EXT_A) tick_d = ext_a_i & ~ext_a_q;
        else if (psc_i == PSC_EXT_B) tick_d = ext_b_i & ~ext_b_q;
        else tick_d = tk.div_tick[psc_i];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) tick_o <= 1'b0;
        else tick_o <= tick_d;
    end

    chk_ext_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        (psc_i == PSC_EXT_B && ext_b_i && !ext_b_q) |=> tick_o)
        else $error("external clock B edge did not tick");

endmodule

// ### logic/mtc_top.sv
// Mode, I/O control and count-clock configuration for a five-channel timer
//
// What this block does
// - Channels 3,4 codes 0-5 divide by 1..1024
// - Codes 6,7 count external input A, B edges
// - Each channel has 8-bit read/write mode register
// - Mode bits 7,6 read one, ignore writes
// - Bit 5 pairs B with D, D events suppressed
// - Bit 4 pairs A with C, C events suppressed
// - Channels 1,2: bits 5,4 read zero
// - Mode 0000 normal, 0010 PWM1, 0011 PWM2
// - Codes 0100-0111 are phase counting 1-4
// - Code 1000 is reset-synchronous PWM
// - Codes 1101,1110,1111 complementary PWM transfer variants
// - Channel 3 sync modes make channel 4 follow
// - Eight 8-bit read/write I/O control registers
// - Initial pin level applies while stopped, and in PWM2 on counter clear
// - PWM2: level set when counter clears
// - Buffered C/D ignore their I/O setting
// - Bits 7:4 set B, 3:0 set A
// - Buffered C/D never clear the counter
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
module mtc_top
    import mtc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // External count clocks
    input wire logic ext_clk_a_i,
    input wire logic ext_clk_b_i,
    // Raw channel events
    input wire logic [4:0] match_c_i,
    input wire logic [4:0] match_d_i,
    input wire logic [4:0] cnt_clr_i,
    // Configuration outputs
    output logic tick3_o,
    output logic tick4_o,
    output logic [4:0] run_o,
    output logic [19:0] eff_md_o,
    output logic [4:0] buf_ac_o,
    output logic [4:0] buf_bd_o,
    output logic [4:0] evt_c_o,
    output logic [4:0] evt_d_o,
    output logic [19:0] pin_lvl_o,
    output logic [19:0] pin_oe_o
);
    import mtc_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] reg_adr(input logic [7:0] base, input int unsigned idx);
        return base + 8'(idx * 4);
    endfunction

    function automatic logic has_cd(input int unsigned ch);
        return (ch == 0) || (ch == 3) || (ch == 4);
    endfunction

    // Index of the register holding the A/B codes of a channel
    function automatic int unsigned io_hi(input int unsigned ch);
        int unsigned r;
        r = 0;
        case (ch)
            1: r = 2;
            2: r = 3;
            3: r = 4;
            4: r = 6;
            default: r = 0;
        endcase
        return r;
    endfunction

    // Output-compare codes with an initial level give {enable, level}
    function automatic logic [1:0] init_out(input logic [3:0] code);
        if (!code[3] && code[1:0] != 2'h0) return {1'b1, code[2]};
        return 2'h0;
    endfunction

    function automatic logic is_sync(input logic [3:0] md);
        mtc_mode_e m;
        m = decode_mode(md);
        return (m == MODE_RSPWM) || (m == MODE_CPWM);
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [5:0] mode_q [NUM_CH];
    logic [7:0] io_q [NUM_IO];
    logic [4:0] run_q;
    logic [2:0] psc3_q;
    logic [2:0] psc4_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [31:0] rd_d;
    logic acc;
    logic wr;
    logic sync3;
    logic [5:0] eff_mode [NUM_CH];
    logic [2:0] psc4_eff;
    logic tick3_w;
    logic tick4_w;

    assign acc = cyc_i & stb_i & ~ack_q;
    assign wr = acc & we_i & sel_i[0];

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) ack_q <= 1'b0;
        else ack_q <= acc;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) dat_q <= '0;
        else if (acc) dat_q <= we_i ? 32'h0 : rd_d;
    end

    // ------------------------------------------------------------
    // Mode registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_CH; i++) mode_q[i] <= MODE_RST;
        end else if (wr) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (adr_i == reg_adr(MODE_BASE, i)) begin
                    if (has_cd(i)) mode_q[i] <= dat_i[5:0];
                    else mode_q[i] <= {2'h0, dat_i[3:0]};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // I/O control, start and prescale registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_IO; i++) io_q[i] <= IO_RST;
        end else if (wr) begin
            for (int i = 0; i < NUM_IO; i++) begin
                if (adr_i == reg_adr(IO_BASE, i)) io_q[i] <= dat_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) run_q <= '0;
        else if (wr && adr_i == START_OFS) run_q <= dat_i[4:0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            psc3_q <= PSC_RST;
            psc4_q <= PSC_RST;
        end else if (wr && adr_i == PSC_OFS) begin
            psc3_q <= dat_i[2:0];
            psc4_q <= dat_i[PSC4_LSB +: 3];
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_d = 32'h0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (adr_i == reg_adr(MODE_BASE, i)) rd_d = {24'h0, MODE_RSVD_VAL, mode_q[i]};
        end
        for (int i = 0; i < NUM_IO; i++) begin
            if (adr_i == reg_adr(IO_BASE, i)) rd_d = {24'h0, io_q[i]};
        end
        if (adr_i == START_OFS) rd_d = {27'h0, run_q};
        if (adr_i == PSC_OFS) rd_d = {26'h0, psc4_q, psc3_q};
        if (adr_i == EFF_OFS) rd_d = {12'h0, eff_md_o};
    end

    // ------------------------------------------------------------
    // Effective configuration
    // ------------------------------------------------------------
    assign sync3 = is_sync(mode_q[3][3:0]);

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) eff_mode[i] = mode_q[i];
        if (sync3) eff_mode[4] = mode_q[3];
    end

    assign psc4_eff = sync3 ? psc3_q : psc4_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eff_md_o <= '0;
            buf_ac_o <= '0;
            buf_bd_o <= '0;
            run_o <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                eff_md_o[i*4 +: 4] <= eff_mode[i][3:0];
                buf_ac_o[i] <= eff_mode[i][MODE_BFA_BIT];
                buf_bd_o[i] <= eff_mode[i][MODE_BFB_BIT];
            end
            run_o <= run_q;
        end
    end

    // Buffered C/D produce neither events nor counter clears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_c_o <= '0;
            evt_d_o <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                evt_c_o[i] <= match_c_i[i] & ~eff_mode[i][MODE_BFA_BIT];
                evt_d_o[i] <= match_d_i[i] & ~eff_mode[i][MODE_BFB_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Pin initial levels
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_lvl_o <= '0;
            pin_oe_o <= '0;
        end else begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                logic [3:0] code [4];
                logic [1:0] o;
                logic apply;
                logic en;
                code[0] = io_q[io_hi(ch)][3:0];
                code[1] = io_q[io_hi(ch)][IO_B_LSB +: 4];
                code[2] = io_q[io_hi(ch) + 1][3:0];
                code[3] = io_q[io_hi(ch) + 1][IO_B_LSB +: 4];
                apply = !run_q[ch]
                    || (decode_mode(eff_mode[ch][3:0]) == MODE_PWM2 && cnt_clr_i[ch]);
                for (int p = 0; p < 4; p++) begin
                    en = (p < 2) || has_cd(ch);
                    if (p == 2 && eff_mode[ch][MODE_BFA_BIT]) en = 1'b0;
                    if (p == 3 && eff_mode[ch][MODE_BFB_BIT]) en = 1'b0;
                    o = init_out(code[p]);
                    if (apply) begin
                        pin_oe_o[ch*4 + p] <= o[1] & en;
                        pin_lvl_o[ch*4 + p] <= o[0] & en;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Count clock selection
    // ------------------------------------------------------------
    mtc_tick_if tk_if ();

    mtc_prescaler u_presc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tk(tk_if.src)
    );

    mtc_tick_sel u_sel3 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .psc_i(psc3_q),
        .ext_a_i(ext_clk_a_i),
        .ext_b_i(ext_clk_b_i),
        .tk(tk_if.dst),
        .tick_o(tick3_w)
    );

    mtc_tick_sel u_sel4 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .psc_i(psc4_eff),
        .ext_a_i(ext_clk_a_i),
        .ext_b_i(ext_clk_b_i),
        .tk(tk_if.dst),
        .tick_o(tick4_w)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick3_o <= 1'b0;
            tick4_o <= 1'b0;
        end else begin
            tick3_o <= tick3_w;
            tick4_o <= tick4_w;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_mode_rsvd_read: assert property (
        (acc && !we_i && adr_i == MODE_BASE) |=> ack_o && dat_o[7:6] == MODE_RSVD_VAL)
        else $error("mode reserved bits not read as ones");

    chk_mode_write: assert property (
        (wr && adr_i == reg_adr(MODE_BASE, 3)) |=> mode_q[3] == $past(dat_i[5:0]))
        else $error("channel 3 mode write lost");

    chk_ch12_nobuf: assert property (
        mode_q[1][5:4] == 2'h0 && mode_q[2][5:4] == 2'h0)
        else $error("channel 1/2 buffer bits not zero");

    chk_buf_c_mask: assert property (
        (eff_mode[0][MODE_BFA_BIT] && match_c_i[0]) |=> !evt_c_o[0])
        else $error("buffered C still produced an event");

    chk_buf_d_pass: assert property (
        (!eff_mode[3][MODE_BFB_BIT] && match_d_i[3]) |=> evt_d_o[3])
        else $error("unbuffered D event lost");

    chk_ch4_follow: assert property (
        sync3 ##1 sync3 |-> eff_md_o[19:16] == $past(mode_q[3][3:0]))
        else $error("channel 4 did not follow channel 3");

    chk_init_stop: assert property (
        (!run_q[1] && io_q[2][3:0] == 4'h5) |=> pin_oe_o[4] && pin_lvl_o[4])
        else $error("initial level not applied while stopped");

    chk_ack_pulse: assert property (
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    chk_cd_ignored: assert property (
        (eff_mode[0][MODE_BFA_BIT] && !run_q[0]) |=> !pin_oe_o[2])
        else $error("buffered C pin still enabled");

    cov_sync3: cover property (sync3 ##1 tick4_o);
    cov_buffer: cover property (buf_bd_o[0] && match_d_i[0]);
    cov_pwm2_clear: cover property (run_q[0] && cnt_clr_i[0] && eff_md_o[3:0] == MD_PWM2);

endmodule

// ### tb/mtc_tb_top.sv
// Self-checking bench for the timer channel configuration block
`timescale 1ns/10ps
module mtc_tb_top;
    import mtc_pkg::*;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ext_clk_a_i, ext_clk_b_i, ack_o, tick3_o, tick4_o;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rng, q, r;
    logic [4:0] match_c_i, match_d_i, cnt_clr_i, run_o, buf_ac_o, buf_bd_o, evt_c_o, evt_d_o;
    logic [19:0] eff_md_o, pin_lvl_o, pin_oe_o;
    logic [29:0] cfg;
    logic [7:0] mode_w [5];
    logic [15:0] legal [5];
    logic [3:0] md;
    logic [1:0] pa, pb;
    int miscompares = 0;
    int check_count = 0;
    int n3, n4;

    mtc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .ext_clk_a_i(ext_clk_a_i), .ext_clk_b_i(ext_clk_b_i), .match_c_i(match_c_i),
        .match_d_i(match_d_i), .cnt_clr_i(cnt_clr_i), .tick3_o(tick3_o), .tick4_o(tick4_o),
        .run_o(run_o), .eff_md_o(eff_md_o), .buf_ac_o(buf_ac_o), .buf_bd_o(buf_bd_o),
        .evt_c_o(evt_c_o), .evt_d_o(evt_d_o), .pin_lvl_o(pin_lvl_o), .pin_oe_o(pin_oe_o));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
        input logic [3:0] s);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            miscompares++;
            end_of_test();
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 4'h1);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 8'h00, 4'h1);
        check(q, exp);
    endtask

    task automatic setm(input int c, input logic [7:0] v);
        mode_w[c] = v;
        wr(MODE_BASE + 8'(c * 4), v);
    endtask

    function automatic logic [7:0] mode_rd(input int c, input logic [7:0] w);
        logic [7:0] v;
        v = {2'b11, w[5:0]};
        if (c == 1 || c == 2) v[5:4] = 2'b00;
        return v;
    endfunction

    function automatic logic [29:0] cfg_exp();
        logic [7:0] v;
        logic [4:0] ac, bd;
        logic [19:0] e;
        for (int c = 0; c < 5; c++) begin
            v = mode_rd(c, mode_w[c]);
            if (c == 4 && mode_w[3][3:0] inside {4'h8, 4'hd, 4'he, 4'hf}) v = mode_rd(3, mode_w[3]);
            e[c*4+:4] = v[3:0];
            ac[c] = v[4];
            bd[c] = v[5];
        end
        return {bd, ac, e};
    endfunction

    function automatic logic [1:0] pin_exp(input logic [3:0] code);
        logic oe;
        oe = ~code[3] & (|code[1:0]);
        return {oe, oe & code[2]};
    endfunction

    task automatic period(input int which, input int exp);
        int n;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (((which == 0) ? tick3_o : tick4_o) !== 1'b1 && n < 2100);
        end
        check(32'(n), 32'(exp));
        if (n >= 2100) end_of_test();
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {cyc_i, stb_i, we_i, ext_clk_a_i, ext_clk_b_i} = '0;
        {adr_i, sel_i, dat_i, match_c_i, match_d_i, cnt_clr_i} = '0;
        rst_i = 1'b1;
        rng = 32'hd5a4;
        legal = '{16'h000d, 16'h00fd, 16'h00fd, 16'he105, 16'h0005};
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check(eff_md_o, 0);
        check(pin_oe_o, 0);
        for (int c = 0; c < 5; c++) rdc(MODE_BASE + 8'(c * 4), 32'hc0);
        for (int i = 0; i < 8; i++) rdc(IO_BASE + 8'(i * 4), 32'h0);
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            wr(IO_BASE + 8'(i * 4), r[7:0]);
            rdc(IO_BASE + 8'(i * 4), {24'h0, r[7:0]});
        end
        wr(8'hfc, 8'hff);
        rdc(8'hfc, 32'h0);
        rdc(MODE_BASE, 32'hc0);
        // Random legal modes, then each legal code on channels 1 and 3
        repeat (4) begin
            for (int c = 0; c < 5; c++) begin
                do begin
                    r = rnd();
                    md = r[3:0];
                end while (legal[c][md] !== 1'b1);
                setm(c, {r[7:4], md});
            end
            repeat (3) @(posedge clk_i);
            check({2'b0, buf_bd_o, buf_ac_o, eff_md_o}, {2'b0, cfg_exp()});
            for (int c = 0; c < 5; c++) rdc(MODE_BASE + 8'(c * 4), mode_rd(c, mode_w[c]));
        end
        setm(4, 8'h32);
        for (int m = 0; m < 16; m++) begin
            if (legal[1][m]) setm(1, 8'(m));
            if (legal[3][m]) setm(3, 8'(m));
            repeat (3) @(posedge clk_i);
            cfg = cfg_exp();
            check(eff_md_o, cfg[19:0]);
            check(buf_ac_o, cfg[24:20]);
            rdc(EFF_OFS, {12'h0, cfg[19:0]});
        end
        wb(1'b1, MODE_BASE, 8'h02, 4'he);
        rdc(MODE_BASE, mode_rd(0, mode_w[0]));
        for (int c = 0; c < 5; c++) setm(c, 8'h00);
        // Count clock selection
        for (int k = 0; k < 6; k++) begin
            wr(PSC_OFS, {2'b0, 3'(5 - k), 3'(k)});
            period(0, 4 ** k);
            period(1, 4 ** (5 - k));
        end
        wr(PSC_OFS, 8'h3e);
        repeat (2) @(posedge clk_i);
        n3 = 0;
        n4 = 0;
        for (int i = 0; i < 44; i++) begin
            @(posedge clk_i);
            ext_clk_a_i <= (i < 40) ? i[1] : 1'b0;
            ext_clk_b_i <= (i < 40) ? i[2] : 1'b0;
            n3 += int'(tick3_o);
            n4 += int'(tick4_o);
        end
        check(32'(n3), 32'd10);
        check(32'(n4), 32'd5);
        setm(3, 8'h08);
        setm(4, 8'h02);
        wr(PSC_OFS, 8'h28);
        period(1, 1);
        setm(3, 8'h00);
        // Event gating by buffer pairing
        setm(0, 8'h30);
        setm(1, 8'h30);
        setm(3, 8'h10);
        setm(4, 8'h20);
        cfg = cfg_exp();
        repeat (16) begin
            r = rnd();
            match_c_i <= r[4:0];
            match_d_i <= r[9:5];
            repeat (2) @(posedge clk_i);
            check(evt_c_o, r[4:0] & ~cfg[24:20]);
            check(evt_d_o, r[9:5] & ~cfg[29:25]);
        end
        for (int c = 0; c < 5; c++) setm(c, 8'h00);
        // Initial pin levels
        for (int m = 0; m < 16; m++) begin
            wr(8'h28, {~4'(m), 4'(m)});
            repeat (3) @(posedge clk_i);
            pa = pin_exp(4'(m));
            pb = pin_exp(~4'(m));
            check({pin_oe_o[5:4], pin_lvl_o[5:4]}, {pb[1], pa[1], pb[0], pa[0]});
            check(pin_oe_o[7:6], 0);
        end
        wr(8'h28, 8'h55);
        wr(START_OFS, 8'h02);
        @(posedge clk_i);
        check(run_o, 5'h02);
        wr(8'h28, 8'h11);
        repeat (3) @(posedge clk_i);
        check(pin_lvl_o[5:4], 2'b11);
        wr(START_OFS, 8'h00);
        setm(0, 8'h03);
        wr(8'h20, 8'h11);
        wr(START_OFS, 8'h01);
        wr(8'h20, 8'h55);
        repeat (3) @(posedge clk_i);
        check(pin_lvl_o[1:0], 2'b00);
        cnt_clr_i <= 5'h01;
        @(posedge clk_i);
        cnt_clr_i <= 5'h00;
        repeat (3) @(posedge clk_i);
        check(pin_lvl_o[1:0], 2'b11);
        wr(START_OFS, 8'h00);
        setm(0, 8'h30);
        wr(8'h24, 8'h55);
        repeat (3) @(posedge clk_i);
        check(pin_oe_o[3:2], 2'b00);
        setm(0, 8'h00);
        repeat (3) @(posedge clk_i);
        check(pin_oe_o[3:2], 2'b11);
        end_of_test();
    end
endmodule
